// ===== signal_monitor_fault_timing.v
// Fault timing core of a traffic signal conflict monitor
`timescale 1ns/1ps
`default_nettype none
`include "signal_monitor_defs.vh"

module signal_monitor_fault_timing #(
    parameter CHANNELS = 16,
    parameter TICK_CYC = `TICK_PERIOD_US * `CLK_MHZ
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Field inputs, already comparator levels
    input wire [CHANNELS-1:0] ch_green,
    input wire [CHANNELS-1:0] ch_yellow,
    input wire [CHANNELS-1:0] ch_red,
    input wire conflict_sense,
    input wire supply_low,
    input wire watchdog_in,
    input wire line_ok,
    // Configuration
    input wire [2:0] min_yellow_time,
    input wire [CHANNELS-1:0] red_monitor_sel,
    input wire red_enable,
    input wire flash_coil_sense,
    input wire fault_reset,
    // Fault outputs
    output reg conflict_fault,
    output reg red_fail_fault,
    output reg yellow_fail_fault,
    output reg supply_fault,
    output reg watchdog_lapse_fault,
    output reg [CHANNELS-1:0] fault_channels,
    output wire failed_state,
    output wire stop_timing,
    output wire monitoring_active
);

// -----------------------------------------------------------------
// Millisecond tick
// -----------------------------------------------------------------
// Counting in ms keeps the two counters on each of the sixteen channels narrow
reg [31:0] pre_q;
wire tick;

assign tick = (pre_q == TICK_CYC - 1);

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        pre_q <= 32'h0;
    else if (tick)
        pre_q <= 32'h0;
    else
        pre_q <= pre_q + 32'h1;
end

// -----------------------------------------------------------------
// Watchdog edge detect
// -----------------------------------------------------------------
reg wd_q;
wire wd_edge;

assign wd_edge = wd_q ^ watchdog_in;

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
        wd_q <= 1'b0;
    else
        wd_q <= watchdog_in;
end

// -----------------------------------------------------------------
// Line recovery sequencer
// -----------------------------------------------------------------
localparam ST_OFF = 3'd0;
localparam ST_HOLD = 3'd1;
localparam ST_COUNT = 3'd2;
localparam ST_NORMAL = 3'd3;
localparam ST_WD_FAIL = 3'd4;

reg [2:0] state_q;
reg [2:0] state_d;
reg [13:0] rec_ms_q;
reg [2:0] edges_q;
wire wd_expired;

assign monitoring_active = (state_q == ST_NORMAL);

always @*
begin
    state_d = state_q;
    case (state_q)
        ST_OFF:
            if (line_ok)
                state_d = ST_HOLD;
        ST_HOLD:
            if (!line_ok)
                state_d = ST_OFF;
            else if (rec_ms_q >= `HOLD_MS)
                state_d = ST_COUNT;
        ST_COUNT:
            // R10: edges or elapsed time
            if (!line_ok)
                state_d = ST_OFF;
            else if ((wd_edge && edges_q == `RESUME_EDGES - 3'h1) ||
                     rec_ms_q >= `RESUME_MS)
                state_d = ST_NORMAL;
        ST_NORMAL:
            // R9: watchdog lapse fails
            if (wd_expired)
                state_d = ST_WD_FAIL;
            else if (!line_ok)
                state_d = ST_OFF;
        ST_WD_FAIL:
            // Held until an explicit reset from the operator
            if (fault_reset)
                state_d = ST_OFF;
        default:
            state_d = ST_OFF;
    endcase
end

always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        state_q <= ST_OFF;
        rec_ms_q <= 14'h0;
        edges_q <= 3'h0;
    end
    else
    begin
        state_q <= state_d;
        if (state_q == ST_OFF)
            rec_ms_q <= 14'h0;
        else if (tick && rec_ms_q != `RESUME_MS)
            rec_ms_q <= rec_ms_q + 14'h1;
        if (state_q != ST_COUNT)
            edges_q <= 3'h0;
        else if (wd_edge)
            edges_q <= edges_q + 3'h1;
    end
end

// -----------------------------------------------------------------
// Duration qualifiers
// -----------------------------------------------------------------
wire suspend;
wire [CHANNELS-1:0] multi_in;
wire [CHANNELS-1:0] red_watch;
wire [CHANNELS-1:0] red_expired;
wire conflict_expired;
wire supply_expired;

assign suspend = !monitoring_active;

// Flash coil means maintenance flash, so red checking is off
assign red_watch = red_monitor_sel &
    {CHANNELS{red_enable & !flash_coil_sense}};

// R1: conflict qualifier
persist_timer #(.WIDTH(12), .LIMIT(`CONFLICT_MS)) u_conflict (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .clear(suspend),
    .cond(conflict_sense | (|multi_in)),
    .expired(conflict_expired)
);

// R6: supply qualifier
persist_timer #(.WIDTH(12), .LIMIT(`SUPPLY_MS)) u_supply (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .clear(suspend),
    .cond(supply_low),
    .expired(supply_expired)
);

// R7: watchdog lapse qualifier
persist_timer #(.WIDTH(12), .LIMIT(`WATCHDOG_MS)) u_watchdog (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .clear(suspend | wd_edge),
    .cond(1'b1),
    .expired(wd_expired)
);

// -----------------------------------------------------------------
// Per-channel red fail and yellow timing
// -----------------------------------------------------------------
wire [12:0] min_yel_ms;
wire [CHANNELS-1:0] yel_short;

// R4: switch selected minimum
assign min_yel_ms = `YEL_BASE_MS + `YEL_STEP_MS * {10'h0, min_yellow_time};

genvar ch;
generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
        reg [12:0] ycnt_q;
        reg yel_q;

        assign multi_in[ch] = (ch_green[ch] & ch_yellow[ch]) |
            (ch_green[ch] & ch_red[ch]) | (ch_yellow[ch] & ch_red[ch]);

        // R2: lack of output qualifier
        persist_timer #(.WIDTH(12), .LIMIT(`RED_FAIL_MS)) u_red (
            .sys_clk(sys_clk),
            .rst(rst),
            .tick(tick),
            .clear(suspend | !red_watch[ch]),
            .cond(!(ch_green[ch] | ch_yellow[ch] | ch_red[ch])),
            .expired(red_expired[ch])
        );

        // R3: short yellow on its falling edge
        assign yel_short[ch] = yel_q & !ch_yellow[ch] & monitoring_active &
            (ycnt_q < min_yel_ms);

        // R5: count only while yellow on
        always @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                ycnt_q <= 13'h0;
                yel_q <= 1'b0;
            end
            else
            begin
                yel_q <= ch_yellow[ch];
                if (!ch_yellow[ch])
                    ycnt_q <= 13'h0;
                else if (tick && ycnt_q != `YEL_MAX_MS)
                    ycnt_q <= ycnt_q + 13'h1;
            end
        end
    end
endgenerate

// -----------------------------------------------------------------
// Latched faults
// -----------------------------------------------------------------
// A new event in the reset cycle still latches: set wins
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        conflict_fault <= 1'b0;
        red_fail_fault <= 1'b0;
        yellow_fail_fault <= 1'b0;
        supply_fault <= 1'b0;
        watchdog_lapse_fault <= 1'b0;
        fault_channels <= {CHANNELS{1'b0}};
    end
    else
    begin
        // R1: declare conflict
        conflict_fault <= (conflict_fault & !fault_reset) | conflict_expired;
        // R2: declare red fail
        red_fail_fault <= (red_fail_fault & !fault_reset) | (|red_expired);
        // R3: declare yellow fail
        yellow_fail_fault <= (yellow_fail_fault & !fault_reset) |
            (|yel_short);
        // R6: declare supply fault
        supply_fault <= (supply_fault & !fault_reset) | supply_expired;
        // R9: watchdog error state
        watchdog_lapse_fault <= (watchdog_lapse_fault & !fault_reset) |
            (monitoring_active & wd_expired);
        fault_channels <= (fault_channels & {CHANNELS{!fault_reset}}) |
            red_expired | yel_short | (multi_in & {CHANNELS{conflict_expired}});
    end
end

assign failed_state = conflict_fault | red_fail_fault | yellow_fail_fault |
    supply_fault | watchdog_lapse_fault;

// R9: stop timing to controller
assign stop_timing = watchdog_lapse_fault;

endmodule // signal_monitor_fault_timing

`default_nettype wire

// ===== signal_monitor_defs.vh
// Timing and encoding constants for the signal monitor fault timing block
// Behaviour
// R1: Ignore conflict or multiple input under 200 ms; fault beyond 450 ms.
// R2: Channel with no active output: no fault under 1200 ms, fault beyond 1500.
// R3: Yellow ending before minimum yellow is a fault; longer yellow passes.
// R4: Minimum yellow set by switches, 2.7 s upward in 0.2 s steps.
// R5: Yellow timer counts only while the yellow input is actually on.
// R6: Ignore +24 VDC dip under 200 ms; supply fault beyond 500 ms.
// R7: Watchdog edges within 900 ms pass; fault after 1100 ms without edge.
// R8: Controller toggles watchdog so no quiet interval exceeds 900 ms.
// R9: Watchdog fault enters failed state and raises stop timing.
// R10: After line recovery resume after 5 watchdog edges or 10 s.
// R11: Each qualifier uses one fixed threshold inside its band, logic inputs.
`ifndef SIGNAL_MONITOR_DEFS_VH
`define SIGNAL_MONITOR_DEFS_VH

// -----------------------------------------------------------------
// Clock and time base
// -----------------------------------------------------------------
`define CLK_MHZ 40
`define TICK_PERIOD_US 1000

// -----------------------------------------------------------------
// Qualifier thresholds in milliseconds
// -----------------------------------------------------------------
// 325 ms, inside 200..450
`define CONFLICT_MS 12'h145
// 1350 ms, inside 1200..1500
`define RED_FAIL_MS 12'h546
// 350 ms, inside 200..500
`define SUPPLY_MS 12'h15e
// 1000 ms, inside 900..1100
`define WATCHDOG_MS 12'h3e8

// -----------------------------------------------------------------
// Line recovery sequence
// -----------------------------------------------------------------
// 4000 ms hold, 10000 ms resume limit
`define HOLD_MS 14'h0fa0
`define RESUME_MS 14'h2710
`define RESUME_EDGES 3'h5

// -----------------------------------------------------------------
// Minimum yellow: base 2700 ms plus 200 ms per switch step
// -----------------------------------------------------------------
`define YEL_BASE_MS 13'h0a8c
`define YEL_STEP_MS 13'h00c8
`define YEL_MAX_MS 13'h1fff

`endif

// ===== persist_timer.v
// Duration qualifier: flags a condition that has held for LIMIT ticks
`timescale 1ns/1ps
`default_nettype none

module persist_timer #(
    parameter WIDTH = 12,
    parameter [WIDTH-1:0] LIMIT = 12'h3e8
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Control
    input wire tick,
    input wire clear,
    input wire cond,
    // Result
    output reg expired
);

reg [WIDTH-1:0] cnt_q;

// R11: fixed threshold
always @(posedge sys_clk or posedge rst)
begin
    if (rst)
    begin
        cnt_q <= {WIDTH{1'b0}};
        expired <= 1'b0;
    end
    else if (clear || !cond)
    begin
        // Any break in the condition restarts the qualification
        cnt_q <= {WIDTH{1'b0}};
        expired <= 1'b0;
    end
    else if (tick && cnt_q != LIMIT)
    begin
        cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        expired <= 1'b0;
    end
    else
    begin
        expired <= (cnt_q == LIMIT);
    end
end

endmodule // persist_timer

`default_nettype wire

// ===== ctrl_model.sv
// Controller watchdog stand-in
`timescale 1ns/1ps
`default_nettype none
module ctrl_model #(
    parameter HALF = 1000
) (
    // Clock
    input wire logic sys_clk,
    // Control
    input wire logic run,
    // Watchdog line
    output var logic wd
);
    int cnt = 0;
    initial wd = 1'b0;
    always @(negedge sys_clk)
    begin
        if (run)
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (run && cnt == HALF - 1)
            wd <= ~wd;
    end
endmodule // ctrl_model
`default_nettype wire

// ===== fault_timing_checker.sv
// Port assertions for the fault timing block
`timescale 1ns/1ps
`default_nettype none
module fault_timing_checker #(
    parameter CHANNELS = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Inputs
    input wire supply_low,
    input wire watchdog_in,
    input wire line_ok,
    input wire red_enable,
    input wire flash_coil_sense,
    input wire fault_reset,
    // Outputs
    input wire conflict_fault,
    input wire red_fail_fault,
    input wire yellow_fail_fault,
    input wire supply_fault,
    input wire watchdog_lapse_fault,
    input wire [CHANNELS-1:0] fault_channels,
    input wire failed_state,
    input wire stop_timing,
    input wire monitoring_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_stop_mirror: assert property (
        stop_timing == watchdog_lapse_fault) else $error("stop mismatch");
    chk_failed_any: assert property (
        failed_state == (conflict_fault | red_fail_fault | yellow_fail_fault
        | supply_fault | watchdog_lapse_fault)) else $error("failed mismatch");
    chk_wd_drops: assert property (
        $rose(watchdog_lapse_fault) |-> ##[0:2] !monitoring_active)
        else $error("still monitoring");
    chk_wd_quiet: assert property (
        $rose(watchdog_lapse_fault) |-> $past(watchdog_in) ==
        $past(watchdog_in, 2) && $past(monitoring_active))
        else $error("lapse too early");
    chk_supply_hold: assert property (
        supply_fault && !fault_reset |=> supply_fault)
        else $error("supply fault lost");
    chk_supply_cause: assert property (
        $rose(supply_fault) |-> $past(supply_low, 4))
        else $error("supply fault unprompted");
    chk_red_gate: assert property (
        $rose(red_fail_fault) |-> $past(red_enable && !flash_coil_sense))
        else $error("red fail while disabled");
    chk_yel_chan: assert property (
        $rose(yellow_fail_fault) |-> |fault_channels)
        else $error("no yellow channel");
    chk_line_drop: assert property (
        !line_ok |=> !monitoring_active) else $error("active without line");
    chk_idle_quiet: assert property (
        $rose(conflict_fault) |-> $past(monitoring_active))
        else $error("conflict while idle");
endmodule // fault_timing_checker
bind signal_monitor_fault_timing fault_timing_checker #(
    .CHANNELS(CHANNELS)
) chk (
    .sys_clk(sys_clk),
    .rst(rst),
    .supply_low(supply_low),
    .watchdog_in(watchdog_in),
    .line_ok(line_ok),
    .red_enable(red_enable),
    .flash_coil_sense(flash_coil_sense),
    .fault_reset(fault_reset),
    .conflict_fault(conflict_fault),
    .red_fail_fault(red_fail_fault),
    .yellow_fail_fault(yellow_fail_fault),
    .supply_fault(supply_fault),
    .watchdog_lapse_fault(watchdog_lapse_fault),
    .fault_channels(fault_channels),
    .failed_state(failed_state),
    .stop_timing(stop_timing),
    .monitoring_active(monitoring_active)
);
`default_nettype wire

// ===== signal_monitor_fault_timing_tb.sv
// Self-checking bench for the fault timing block
`timescale 1ns/1ps
`default_nettype none
module signal_monitor_fault_timing_tb;
    // Short tick keeps the long ms counts affordable
    localparam TK = 2;
    logic sys_clk, rst, conflict_sense, supply_low, watchdog_in, line_ok;
    logic red_enable, flash_coil_sense, fault_reset, run;
    logic [15:0] ch_green, ch_yellow, ch_red, red_monitor_sel;
    logic [15:0] fault_channels;
    logic [2:0] min_yellow_time;
    logic conflict_fault, red_fail_fault, yellow_fail_fault, supply_fault;
    logic watchdog_lapse_fault, failed_state, stop_timing, monitoring_active;
    int error_cnt = 0;
    int cmp_count = 0;
    signal_monitor_fault_timing #(.TICK_CYC(TK)) uut (
        .sys_clk(sys_clk),
        .rst(rst),
        .ch_green(ch_green),
        .ch_yellow(ch_yellow),
        .ch_red(ch_red),
        .conflict_sense(conflict_sense),
        .supply_low(supply_low),
        .watchdog_in(watchdog_in),
        .line_ok(line_ok),
        .min_yellow_time(min_yellow_time),
        .red_monitor_sel(red_monitor_sel),
        .red_enable(red_enable),
        .flash_coil_sense(flash_coil_sense),
        .fault_reset(fault_reset),
        .conflict_fault(conflict_fault),
        .red_fail_fault(red_fail_fault),
        .yellow_fail_fault(yellow_fail_fault),
        .supply_fault(supply_fault),
        .watchdog_lapse_fault(watchdog_lapse_fault),
        .fault_channels(fault_channels),
        .failed_state(failed_state),
        .stop_timing(stop_timing),
        .monitoring_active(monitoring_active)
    );
    ctrl_model #(.HALF(500 * TK)) ctl (.sys_clk(sys_clk), .run(run),
        .wd(watchdog_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic wt(input int t);
        repeat (t * TK) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic clr;
        fault_reset = 1'b1;
        wt(1);
        fault_reset = 1'b0;
    endtask
    task automatic t_recover;
        line_ok = 1'b1;
        run = 1'b1;
        wt(3000);
        chk(monitoring_active, 0);
        for (int i = 0; i < 4000 && monitoring_active !== 1'b1; i++)
            wt(1);
        chk(monitoring_active, 1);
        $display("recovery done");
    endtask
    task automatic t_conflict;
        conflict_sense = 1'b1;
        wt(190);
        conflict_sense = 1'b0;
        wt(5);
        chk(conflict_fault, 0);
        ch_green[3] = 1'b1;
        wt(460);
        ch_green[3] = 1'b0;
        wt(2);
        chk(conflict_fault, 1);
        chk(fault_channels, 16'h0008);
        clr;
        $display("conflict done");
    endtask
    task automatic t_red;
        red_enable = 1'b1;
        ch_red[5] = 1'b0;
        wt(1150);
        chk(red_fail_fault, 0);
        wt(400);
        chk(red_fail_fault, 1);
        flash_coil_sense = 1'b1;
        clr;
        wt(1600);
        chk(red_fail_fault, 0);
        ch_red[5] = 1'b1;
        red_enable = 1'b0;
        flash_coil_sense = 1'b0;
        $display("red fail done");
    endtask
    task automatic t_supply;
        supply_low = 1'b1;
        wt(190);
        supply_low = 1'b0;
        wt(5);
        chk(supply_fault, 0);
        supply_low = 1'b1;
        wt(510);
        supply_low = 1'b0;
        chk(supply_fault, 1);
        clr;
        $display("supply done");
    endtask
    // Gap before red must not count as yellow time
    task automatic yel(input logic [2:0] s, input int d, input logic e);
        min_yellow_time = s;
        ch_red[0] = 1'b0;
        ch_yellow[0] = 1'b1;
        wt(d);
        ch_yellow[0] = 1'b0;
        wt(300);
        ch_red[0] = 1'b1;
        chk({yellow_fail_fault, fault_channels}, e ? 17'h10001 : 17'h0);
        clr;
    endtask
    task automatic t_yellow;
        yel(3'h0, 2800, 1'b0);
        yel(3'h1, 2800, 1'b1);
        yel(3'h7, 4000, 1'b1);
        yel(3'h7, 4200, 1'b0);
        $display("yellow done");
    endtask
    task automatic t_watchdog;
        @(watchdog_in);
        run = 1'b0;
        wt(850);
        chk(watchdog_lapse_fault, 0);
        wt(300);
        chk({watchdog_lapse_fault, stop_timing, monitoring_active}, 3'h6);
        chk(failed_state, 1);
        clr;
        $display("watchdog done");
        t_timed;
    endtask
    // Silent watchdog: resume on elapsed time, then lose the line
    task automatic t_timed;
        wt(9990);
        chk(monitoring_active, 0);
        wt(20);
        chk(monitoring_active, 1);
        line_ok = 1'b0;
        wt(1);
        chk(monitoring_active, 0);
        $display("timed resume done");
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {rst, conflict_sense, supply_low, line_ok, red_enable} = 5'h10;
        {flash_coil_sense, fault_reset, run} = 3'h0;
        {ch_green, ch_yellow, ch_red} = {16'h0, 16'h0, 16'hffff};
        red_monitor_sel = 16'hffff;
        min_yellow_time = 3'h0;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        t_recover;
        t_conflict;
        t_red;
        t_supply;
        t_yellow;
        t_watchdog;
        summarize;
    end
    initial
    begin
        repeat (95000) @(posedge sys_clk);
        error_cnt++;
        summarize;
    end
endmodule // signal_monitor_fault_timing_tb
`default_nettype wire
